//--- src/xmp_pkg.sv
// Purpose: Constants for the external memory port (DRAM/SRAM) block
// Assumes: 25 MHz clock, Wishbone classic register access
// Notes:   Register offsets and field layouts are local choices
//
// Summary of operation
// - Writing the write-data register starts one external write cycle.
// - Config bit picks read start: offset register write or read-data read.
// - Status flags can be polled; masked sticky events drive one interrupt.
// - Data bus is 4 bits for DRAM, 8 bits for SRAM.
// - DRAM words are 16 or 24 bits.
// - SRAM words are 8, 16 or 24 bits.
// - Thirteen DRAM address lines reach 32MB.
// - DRAM refresh runs periodically at one of eight divider rates.
// - SRAM address is 22 bits straight from the address register, covering 4MB.
// - Four selectable SRAM access timings.
// - Two read-offset registers; either supplies the read address.
package xmp_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [4:0] XMP_CTRL_OFS   = 5'h00;
    localparam logic [4:0] XMP_STAT_OFS   = 5'h04;
    localparam logic [4:0] XMP_MASK_OFS   = 5'h08;
    localparam logic [4:0] XMP_WADDR_OFS  = 5'h0c;
    localparam logic [4:0] XMP_WDATA_OFS  = 5'h10;
    localparam logic [4:0] XMP_ROFS0_OFS  = 5'h14;
    localparam logic [4:0] XMP_ROFS1_OFS  = 5'h18;
    localparam logic [4:0] XMP_RDATA_OFS  = 5'h1c;
    // ****************************************
    // Control fields
    // ****************************************
    localparam int XMP_C_SRAM  = 0;
    localparam int XMP_C_WLEN  = 1;
    localparam int XMP_C_RMODE = 3;
    localparam int XMP_C_RSEL  = 4;
    localparam int XMP_C_REF   = 5;
    localparam int XMP_C_STIM  = 8;
    localparam int XMP_C_REN   = 10;
    localparam logic [10:0] XMP_CTRL_RST = 11'h000;
    // Word length codes
    localparam logic [1:0] XMP_WL8  = 2'h0;
    localparam logic [1:0] XMP_WL16 = 2'h1;
    localparam logic [1:0] XMP_WL24 = 2'h2;
    // ****************************************
    // Status fields
    // ****************************************
    localparam int XMP_S_WDONE = 0;
    localparam int XMP_S_RDONE = 1;
    localparam int XMP_S_BUSY  = 2;
    localparam int XMP_NEV     = 2;
    // ****************************************
    // Geometry and timing
    // ****************************************
    localparam int XMP_DRAM_AW  = 13;
    localparam int XMP_DRAM_ADR = 26;
    localparam int XMP_SRAM_ADR = 22;
    localparam int XMP_DRAM_DW  = 4;
    localparam int XMP_SRAM_DW  = 8;
    localparam int XMP_REF_BASE = 64;
    localparam int XMP_CLK_MHZ  = 25;
    localparam int XMP_TRC_NS   = 80;
    localparam int XMP_TRC_CYC  = (XMP_TRC_NS * XMP_CLK_MHZ + 999) / 1000;
endpackage

//--- src/xmp_refresh_div.sv
// Purpose: Refresh request divider with eight selectable factors
// Assumes: Single clock, synchronous reset
// Notes:   Factor is BASE shifted left by the 3-bit select
`timescale 1ns/1ps
module xmp_refresh_div
    import xmp_pkg::*;
#(
    parameter int BASE = XMP_REF_BASE
)
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       en_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    initial
    begin
        if (BASE < 2 || BASE > 4096)
            $error("xmp_refresh_div: BASE out of range");
    end

    logic [19:0] cnt_q;
    logic [19:0] cnt_d;
    logic [19:0] lim;
    logic        tick_d;
    logic        tick_q;

    always_comb
    begin
        lim    = 20'(BASE) << sel_i;
        tick_d = 1'b0;
        cnt_d  = cnt_q + 20'h00001;
        if (!en_i)
            cnt_d = 20'h00000;
        else if (cnt_q >= lim - 20'h00001)
        begin
            cnt_d  = 20'h00000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q  <= 20'h00000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule

//--- src/xmp_top.sv
// Purpose: External memory port, DRAM or SRAM, behind Wishbone registers
// Assumes: 25 MHz clk_i, synchronous active-high reset, memory data returns same clock
// Notes:   One access at a time; new requests while busy are dropped
`timescale 1ns/1ps
module xmp_top
    import xmp_pkg::*;
#(
    parameter int REF_BASE = XMP_REF_BASE
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             irq_o,
    // Memory pins
    output logic [21:0]      mem_addr_o,
    output logic [7:0]       mem_dq_o,
    output logic             mem_dq_oe_o,
    input  wire logic [7:0]  mem_dq_i,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic             ce_n_o,
    output logic             oe_n_o
);
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        XMP_IDLE = 3'b000,
        XMP_ROW  = 3'b001,
        XMP_COL  = 3'b011,
        XMP_BEAT = 3'b010,
        XMP_NEXT = 3'b110,
        XMP_REF  = 3'b111,
        XMP_REF2 = 3'b101
    } xmp_state_t;

    // ****************************************
    // Register state
    // ****************************************
    logic [10:0] ctrl_q, ctrl_d;
    logic [1:0]  stat_q, stat_d;
    logic [1:0]  mask_q, mask_d;
    logic [25:0] waddr_q, waddr_d;
    logic [23:0] wdata_q, wdata_d;
    logic [25:0] rofs0_q, rofs0_d;
    logic [25:0] rofs1_q, rofs1_d;
    logic [23:0] rdata_q, rdata_d;
    logic [31:0] dat_q, dat_d;
    logic        ack_q, ack_d;

    // Engine state
    xmp_state_t  st_q, st_d;
    logic        wr_q, wr_d;
    logic [25:0] addr_q, addr_d;
    logic [23:0] sh_q, sh_d;
    logic [2:0]  beat_q, beat_d;
    logic [2:0]  wait_q, wait_d;
    logic        refp_q, refp_d;
    logic [21:0] pa_q, pa_d;
    logic [7:0]  pd_q, pd_d;
    logic        pdoe_q, pdoe_d;
    logic        ras_q, ras_d, cas_q, cas_d, wen_q, wen_d, ce_q, ce_d, oen_q, oen_d;

    logic        req, wr_hit, rd_hit, start_wr, start_rd, done_wr, done_rd, ref_tick;
    logic        sram;
    logic [1:0]  wlen;
    logic [2:0]  nbeat;
    logic [2:0]  twait;
    logic [3:0]  bw;

    assign sram = ctrl_q[XMP_C_SRAM];
    assign wlen = ctrl_q[XMP_C_WLEN +: 2];

    // ****************************************
    // Refresh divider
    // ****************************************
    xmp_refresh_div #(
        .BASE   (REF_BASE)
    ) u_ref (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (ctrl_q[XMP_C_REN] & ~sram),
        .sel_i  (ctrl_q[XMP_C_REF +: 3]),
        .tick_o (ref_tick)
    );

    // ****************************************
    // Bus decode and registers
    // ****************************************
    assign req    = cyc_i & stb_i & ~ack_q;
    assign wr_hit = req & we_i;
    assign rd_hit = req & ~we_i;
    assign start_wr = wr_hit && adr_i == XMP_WDATA_OFS;
    // Read start source follows the mode bit
    assign start_rd = ctrl_q[XMP_C_RMODE]
                    ? (rd_hit && adr_i == XMP_RDATA_OFS)
                    : (wr_hit && (adr_i == XMP_ROFS0_OFS || adr_i == XMP_ROFS1_OFS));

    always_comb
    begin
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        rofs0_d = rofs0_q;
        rofs1_d = rofs1_q;
        ack_d   = req;
        dat_d   = 32'h00000000;
        stat_d  = stat_q;
        if (wr_hit && adr_i == XMP_STAT_OFS && sel_i[0])
            stat_d = stat_q & ~dat_i[1:0];
        stat_d[XMP_S_WDONE] = stat_d[XMP_S_WDONE] | done_wr;
        stat_d[XMP_S_RDONE] = stat_d[XMP_S_RDONE] | done_rd;
        if (wr_hit)
        begin
            unique case (adr_i)
                XMP_CTRL_OFS:  if (sel_i[0] && sel_i[1]) ctrl_d = dat_i[10:0];
                XMP_MASK_OFS:  if (sel_i[0]) mask_d = dat_i[1:0];
                XMP_WADDR_OFS: waddr_d = dat_i[25:0];
                XMP_WDATA_OFS: wdata_d = dat_i[23:0];
                XMP_ROFS0_OFS: rofs0_d = dat_i[25:0];
                XMP_ROFS1_OFS: rofs1_d = dat_i[25:0];
                default:       ;
            endcase
        end
        if (rd_hit)
        begin
            unique case (adr_i)
                XMP_CTRL_OFS:  dat_d = {21'h000000, ctrl_q};
                XMP_STAT_OFS:  dat_d = {29'h00000000, st_q != XMP_IDLE, stat_q};
                XMP_MASK_OFS:  dat_d = {30'h00000000, mask_q};
                XMP_WADDR_OFS: dat_d = {6'h00, waddr_q};
                XMP_WDATA_OFS: dat_d = {8'h00, wdata_q};
                XMP_ROFS0_OFS: dat_d = {6'h00, rofs0_q};
                XMP_ROFS1_OFS: dat_d = {6'h00, rofs1_q};
                XMP_RDATA_OFS: dat_d = {8'h00, rdata_q};
                default:       dat_d = 32'h00000000;
            endcase
        end
    end

    assign irq_o = |(stat_q & mask_q);

    // ****************************************
    // Access engine
    // ****************************************
    always_comb
    begin
        unique case (wlen)
            XMP_WL8:  nbeat = sram ? 3'h1 : 3'h4;
            XMP_WL16: nbeat = sram ? 3'h2 : 3'h4;
            default:  nbeat = sram ? 3'h3 : 3'h6;
        endcase
        twait = sram ? {1'b0, ctrl_q[XMP_C_STIM +: 2]} : 3'(XMP_TRC_CYC - 1);
        bw    = sram ? 4'h8 : 4'h4;
    end

    always_comb
    begin
        st_d    = st_q;
        wr_d    = wr_q;
        addr_d  = addr_q;
        sh_d    = sh_q;
        beat_d  = beat_q;
        wait_d  = wait_q;
        rdata_d = rdata_q;
        refp_d  = refp_q | ref_tick;
        pa_d    = pa_q;
        pd_d    = pd_q;
        pdoe_d  = 1'b0;
        ras_d   = 1'b1;
        cas_d   = 1'b1;
        wen_d   = 1'b1;
        ce_d    = 1'b1;
        oen_d   = 1'b1;
        done_wr = 1'b0;
        done_rd = 1'b0;
        unique case (st_q)
            XMP_IDLE:
            begin
                beat_d = 3'h0;
                wait_d = twait;
                if (start_wr || start_rd)
                begin
                    wr_d   = start_wr;
                    sh_d   = start_wr ? dat_i[23:0] : 24'h000000;
                    addr_d = start_wr ? waddr_q : (ctrl_q[XMP_C_RSEL] ? rofs1_q : rofs0_q);
                    if (start_rd && !ctrl_q[XMP_C_RMODE])
                        addr_d = dat_i[25:0];
                    st_d   = sram ? XMP_BEAT : XMP_ROW;
                end
                else if (refp_q && !sram)
                begin
                    refp_d = 1'b0;
                    st_d   = XMP_REF;
                end
            end
            XMP_ROW:
            begin
                pa_d  = {9'h000, addr_q[25:13]};
                ras_d = 1'b0;
                st_d  = XMP_COL;
            end
            XMP_COL:
            begin
                pa_d  = {9'h000, addr_q[12:0]};
                ras_d = 1'b0;
                st_d  = XMP_BEAT;
            end
            XMP_BEAT:
            begin
                // Addresses step one bus beat at a time
                if (sram)
                begin
                    pa_d = addr_q[21:0];
                    ce_d = 1'b0;
                end
                else
                begin
                    pa_d  = {9'h000, addr_q[12:0]};
                    ras_d = 1'b0;
                    cas_d = 1'b0;
                end
                wen_d  = ~wr_q;
                oen_d  = wr_q;
                pdoe_d = wr_q;
                pd_d   = sram ? sh_q[7:0] : {4'h0, sh_q[3:0]};
                if (wait_q != 3'h0)
                    wait_d = wait_q - 3'h1;
                else
                    st_d = XMP_NEXT;
            end
            XMP_NEXT:
            begin
                // Capture then shift so the first beat is least significant
                if (sram)
                    sh_d = {wr_q ? 8'h00 : mem_dq_i, sh_q[23:8]};
                else
                    sh_d = {wr_q ? 4'h0 : mem_dq_i[3:0], sh_q[23:4]};
                beat_d = beat_q + 3'h1;
                wait_d = twait;
                // Each beat, nibble or byte, has its own location
                addr_d = addr_q + 26'h0000001;
                ras_d  = sram;
                if (beat_q + 3'h1 == nbeat)
                begin
                    st_d    = XMP_IDLE;
                    done_wr = wr_q;
                    done_rd = ~wr_q;
                    if (!wr_q)
                        rdata_d = sh_d >> (5'h18 - 5'(nbeat) * 5'(bw));
                end
                else
                    st_d = XMP_BEAT;
            end
            XMP_REF:
            begin
                cas_d  = 1'b0;
                wait_d = twait;
                st_d   = XMP_REF2;
            end
            XMP_REF2:
            begin
                cas_d = 1'b0;
                ras_d = 1'b0;
                if (wait_q != 3'h0)
                    wait_d = wait_q - 3'h1;
                else
                    st_d = XMP_IDLE;
            end
            default: st_d = XMP_IDLE;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q  <= XMP_CTRL_RST;
            stat_q  <= 2'h0;
            mask_q  <= 2'h0;
            waddr_q <= 26'h0000000;
            wdata_q <= 24'h000000;
            rofs0_q <= 26'h0000000;
            rofs1_q <= 26'h0000000;
            rdata_q <= 24'h000000;
            dat_q   <= 32'h00000000;
            ack_q   <= 1'b0;
            st_q    <= XMP_IDLE;
            wr_q    <= 1'b0;
            addr_q  <= 26'h0000000;
            sh_q    <= 24'h000000;
            beat_q  <= 3'h0;
            wait_q  <= 3'h0;
            refp_q  <= 1'b0;
            pa_q    <= 22'h000000;
            pd_q    <= 8'h00;
            pdoe_q  <= 1'b0;
            ras_q   <= 1'b1;
            cas_q   <= 1'b1;
            wen_q   <= 1'b1;
            ce_q    <= 1'b1;
            oen_q   <= 1'b1;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            rofs0_q <= rofs0_d;
            rofs1_q <= rofs1_d;
            rdata_q <= rdata_d;
            dat_q   <= dat_d;
            ack_q   <= ack_d;
            st_q    <= st_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            sh_q    <= sh_d;
            beat_q  <= beat_d;
            wait_q  <= wait_d;
            refp_q  <= refp_d;
            pa_q    <= pa_d;
            pd_q    <= pd_d;
            pdoe_q  <= pdoe_d;
            ras_q   <= ras_d;
            cas_q   <= cas_d;
            wen_q   <= wen_d;
            ce_q    <= ce_d;
            oen_q   <= oen_d;
        end
    end

    assign dat_o       = dat_q;
    assign ack_o       = ack_q;
    assign mem_addr_o  = pa_q;
    assign mem_dq_o    = pd_q;
    assign mem_dq_oe_o = pdoe_q;
    assign ras_n_o     = ras_q;
    assign cas_n_o     = cas_q;
    assign we_n_o      = wen_q;
    assign ce_n_o      = ce_q;
    assign oe_n_o      = oen_q;
endmodule

//--- test/xmp_chk.sv
// Purpose: Port assertions for the external memory port
// Assumes: Ack one cycle after a taken request
// Notes:   Strobe bounds are generous on purpose
`timescale 1ns/1ps
module xmp_chk
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic cyc_i,
    input  wire logic stb_i,
    input  wire logic ack_o,
    input  wire logic mem_dq_oe_o,
    input  wire logic ras_n_o,
    input  wire logic cas_n_o,
    input  wire logic we_n_o,
    input  wire logic ce_n_o,
    input  wire logic oe_n_o
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_idle;
        ras_n_o && cas_n_o && we_n_o && ce_n_o && oe_n_o && !ack_o;
    endsequence
    a_ack_answer: assert property (s_req |=> ack_o) else $error("ack missing");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_cas_order: assert property ($fell(cas_n_o) && !we_n_o |-> !ras_n_o) else $error("cas before ras");
    a_write_drive: assert property (!we_n_o |-> mem_dq_oe_o) else $error("write not driven");
    a_read_free: assert property (!oe_n_o |-> !mem_dq_oe_o) else $error("read contention");
    a_mode_excl: assert property (!ras_n_o |-> ce_n_o) else $error("dram and sram both");
    a_ras_bound: assert property ($fell(ras_n_o) |-> ##[1:100] $rose(ras_n_o)) else $error("ras stuck");
    a_ce_bound: assert property ($fell(ce_n_o) |-> ##[1:100] $rose(ce_n_o)) else $error("ce stuck");
    a_reset_idle: assert property ($fell(rst_i) |-> s_idle) else $error("not idle after reset");
endmodule

bind xmp_top xmp_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .mem_dq_oe_o(mem_dq_oe_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o));

//--- test/xmp_mem_model.sv
// Purpose: Behavioural DRAM/SRAM on the memory pins
// Assumes: Strobes sampled on the rising edge
// Notes:   Undriven bus shows inverse of last value
`timescale 1ns/1ps
module xmp_mem_model
(
    input  wire logic        clk_i,
    input  wire logic [21:0] addr_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    output logic [7:0]       dq_o
);
    logic [7:0]  mem [int];
    logic [12:0] row_q = 13'h0000;
    logic        ras_q = 1'b1;
    logic [7:0]  last_q = 8'h00;
    logic [7:0]  rd;
    int          key;
    always @*
    begin
        key = !ce_n_i ? int'(addr_i) : int'({row_q, addr_i[12:0]});
        rd = mem.exists(key) ? mem[key] : 8'h00;
    end
    assign dq_o = (!oe_n_i && (!ce_n_i || !ras_n_i)) ? rd : ~last_q;
    always @(posedge clk_i)
    begin
        ras_q <= ras_n_i;
        if (!ras_n_i && ras_q)
            row_q <= addr_i[12:0];
        if (!oe_n_i)
            last_q <= rd;
        if (!we_n_i && !ce_n_i)
            mem[key] = dq_i;
        else if (!we_n_i && !cas_n_i && !ras_n_i)
            mem[key] = {4'h0, dq_i[3:0]};
    end
endmodule

//--- test/tb_top.sv
// Purpose: Self-checking bench for the external memory port
// Assumes: Refresh base shortened to 4
// Notes:   Memory model checked through hierarchy
`timescale 1ns/1ps
module tb_top
    import xmp_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [4:0]  adr_i = 5'h00;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, irq_o, mem_dq_oe_o, ras_n_o, cas_n_o, we_n_o, ce_n_o, oe_n_o;
    logic [21:0] mem_addr_o;
    logic [7:0]  mem_dq_o, mem_dq_i;
    int n_fail = 0, checked = 0, cycles = 0, falls = 0;
    logic ras_p = 1'b1;
    xmp_top #(.REF_BASE(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .mem_addr_o(mem_addr_o), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o), .mem_dq_i(mem_dq_i),
        .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o));
    xmp_mem_model u_mem (.clk_i(clk_i), .addr_i(mem_addr_o), .dq_i(mem_dq_o), .ras_n_i(ras_n_o),
        .cas_n_i(cas_n_o), .we_n_i(we_n_o), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .dq_o(mem_dq_i));
    // ****************************************
    // Clock, timeout, refresh counting
    // ****************************************
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        ras_p <= ras_n_o;
        if (!ras_n_o && ras_p)
            falls++;
        if (cycles == 60000)
        begin
            n_fail++;
            close_out();
        end
    end
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_st(input int b);
        logic [31:0] s;
        s = 32'h0;
        while (s[b] !== 1'b1)
            rd(XMP_STAT_OFS, s);
        wr(XMP_STAT_OFS, 32'h1 << b);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] q;
        rd(XMP_CTRL_OFS, q);
        chk(q, 32'h0);
        rd(XMP_STAT_OFS, q);
        chk(q, 32'h0);
        wr(5'h02, 32'hffffffff);
        rd(5'h02, q);
        chk(q, 32'h0);
        chk(irq_o, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_sram();
        logic [31:0] q, w, m;
        logic [21:0] a;
        int nb;
        for (int i = 0; i < 4; i++)
        begin
            nb = i % 3 + 1;
            a = 22'h3ffff0 + 22'(i * 4);
            w = 32'h00a5c3e1 ^ 32'(i);
            m = (32'h1 << (8 * nb)) - 32'h1;
            wr(XMP_CTRL_OFS, 32'h1 | 32'(i % 3) << 1 | 32'(i & 1) << 4 | 32'(i) << 8);
            wr(XMP_WADDR_OFS, 32'(a));
            wr(XMP_WDATA_OFS, w);
            wait_st(XMP_S_WDONE);
            for (int b = 0; b < nb; b++)
                chk(u_mem.mem[int'(a) + b], w[8 * b +: 8]);
            wr((i & 1) ? XMP_ROFS1_OFS : XMP_ROFS0_OFS, 32'(a));
            wait_st(XMP_S_RDONE);
            rd(XMP_RDATA_OFS, q);
            chk(q, w & m);
        end
        $display("sram test done");
    endtask
    task automatic t_dram();
        logic [31:0] q, w;
        for (int j = 0; j < 2; j++)
        begin
            w = 32'h005a3c96 + 32'(j);
            wr(XMP_CTRL_OFS, 32'(j + 1) << 1 | 32'(j) << 3 | 32'(j) << 4);
            wr(XMP_WADDR_OFS, 32'h03ffffc0 + 32'(j));
            wr(XMP_WDATA_OFS, w);
            wait_st(XMP_S_WDONE);
            wr(j ? XMP_ROFS1_OFS : XMP_ROFS0_OFS, 32'h03ffffc0 + 32'(j));
            if (j == 1)
                rd(XMP_RDATA_OFS, q);
            wait_st(XMP_S_RDONE);
            rd(XMP_RDATA_OFS, q);
            chk(q, j ? w : (w & 32'hffff));
            // Reading the data register restarts a read in this mode; drain it
            if (j == 1)
                wait_st(XMP_S_RDONE);
        end
        $display("dram test done");
    endtask
    task automatic t_irq();
        logic [31:0] q;
        wr(XMP_CTRL_OFS, 32'h1);
        wr(XMP_MASK_OFS, 32'h1);
        wr(XMP_WDATA_OFS, 32'h77);
        q = 32'h0;
        while (q[XMP_S_WDONE] !== 1'b1)
            rd(XMP_STAT_OFS, q);
        rd(XMP_MASK_OFS, q);
        chk(irq_o, 1'b1);
        wr(XMP_MASK_OFS, 32'h2);
        rd(XMP_MASK_OFS, q);
        chk(irq_o, 1'b0);
        wr(XMP_MASK_OFS, 32'h1);
        wr(XMP_STAT_OFS, 32'h1);
        rd(XMP_STAT_OFS, q);
        chk(q[1:0], 2'b00);
        chk(irq_o, 1'b0);
        $display("irq test done");
    endtask
    task automatic t_refresh();
        int c;
        wr(XMP_CTRL_OFS, 32'h0);
        c = falls;
        repeat (256) @(posedge clk_i);
        chk(falls - c, 0);
        wr(XMP_CTRL_OFS, 32'h400 | 32'h3 << 5);
        c = falls;
        repeat (256) @(posedge clk_i);
        chk((falls - c >= 7) && (falls - c <= 9), 1'b1);
        wr(XMP_CTRL_OFS, 32'h400);
        c = falls;
        repeat (256) @(posedge clk_i);
        chk(falls - c > 9, 1'b1);
        wr(XMP_CTRL_OFS, 32'h0);
        $display("refresh test done");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_sram();
        t_dram();
        t_irq();
        t_refresh();
        close_out();
    end
endmodule
